/* File: logic/bee_engine.sv */
`timescale 1ns/1ps
// Contract
// - The list supports insert at a chosen position and delete at a position.
// - Evaluation stops at the first end entry; later entries are ignored.
// - Rising one-shot is true when its input goes from false to true.
// - Falling one-shot is true when its input goes from true to false.
// - Dual one-shot is true on either transition of its input.
// - Every one-shot output is true for exactly one pass.
// - Up to thirty-two one-shots, each with its own previous input.
// - Inversion takes the single value just before it.
// - OR, AND, NOR, NAND take the N preceding values, N from 2 to 16.
// - OR any true, AND all true, NOR all false, NAND any false.
// - XOR takes two values and is true when exactly one is true.
// - Latch reset dominates; reset is top of stack, set below it.
// - Latch stays set after set drops until reset is asserted.
// - Up to 32 timers started by the preceding value; output readable.
// - Assignment copies the preceding value into one of 64 virtual outputs.
// - Assignment ends the equation; the next parameter starts a new one.
// - A repeated timer or virtual output assignment is a syntax error.
// - Equations are evaluated in entry order.
// - Latches clear at power-up.
// - A setting change taken while idle recompiles and clears every latch.
module bee_engine
    import bee_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire bee_editreq_type edit_req,
    input wire logic setting_change,
    input wire logic eval_tick,
    input wire logic [NUM_OPERANDS-1:0] operands,
    input wire logic [NUM_TIMERS-1:0] timer_out,
    output logic [NUM_TIMERS-1:0] timer_start,
    output logic [NUM_VOUT-1:0] vout,
    output bee_status_type status
);

    // ------------------------------------------------------------
    // Operating notes.
    // ------------------------------------------------------------
    // The engine has three phases: idle, check and evaluation.
    // In idle it takes one edit or setting change per clock.
    // Otherwise it waits for a pending tick.
    // Check walks the list once, up to and including the first end.
    // It records every timer start and virtual output assignment that it meets.
    // Evaluation walks the same span, one parameter per clock.
    // For a list of L entries before the end, both walks take
    // L + 1 clocks after the edge at which they start.
    // A tick that comes while busy is not lost.
    // It stays pending and starts a pass once the engine is idle.
    // Several ticks during one pass collapse into one.
    // That is safe because a pass reads the newest operands.
    // Edits and setting changes made while busy are dropped.
    // Nothing signals the drop, so the configuring side watches busy.
    // This keeps the list stable under the two walkers.
    // The syntax flag blocks every pass until a recompile clears it.
    // Outputs keep the values of the last good pass.
    // Downstream contacts therefore do not chatter during edits.
    // ------------------------------------------------------------
    // Stack.
    // ------------------------------------------------------------
    // The value stack is thirty-two entries deep.
    // It has no overflow guard.
    // A list that keeps operands next to their operator
    // never needs more than seventeen entries.
    // Deeper nesting is the configuring side's concern.
    // Every assignment empties the stack.
    // A fault in one equation therefore cannot leak into the next.
    // ------------------------------------------------------------
    // Gates.
    // ------------------------------------------------------------
    // The gate count comes from the low bits of the argument.
    // It is forced into the legal span of two to sixteen.
    // A bad count can then never read more than sixteen entries below the top.
    // The result replaces the lowest consumed entry.
    // The pointer drops by the count minus one.
    // ------------------------------------------------------------
    // Latches and one-shots.
    // ------------------------------------------------------------
    // Slots are handed out in order of appearance in the list.
    // The count starts afresh on every pass.
    // Inserting a latch ahead of another moves the later one.
    // That is harmless, because every edit clears all latches.
    // One-shot history survives an edit.
    // The first pass after an edit may pulse a slot that moved.
    // A latch pushes back its new state.
    // A set and the latch output therefore rise in one pass.
    // ------------------------------------------------------------
    // Timers.
    // ------------------------------------------------------------
    // The timers themselves live outside the engine.
    // A timer operator drives its start line from the value below.
    // It pushes the timer's present output in that value's place.
    // The timed value thus reaches the equation a pass later.
    // Start lines and virtual outputs are registers.
    // They change only while a pass runs.
    // ------------------------------------------------------------
    // Editing.
    // ------------------------------------------------------------
    // Insert moves the tail up one place from the position.
    // The last entry of the list is lost.
    // Delete moves the tail down one place.
    // The top of the list is filled with an end entry.
    // Both finish in one clock.
    // The price is a wide multiplexer on every entry.

    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE, ST_CHECK, ST_EVAL
    } bee_phase_type;

    typedef struct packed {
        bee_phase_type phase;
        logic [LIST_AW-1:0] pc;
        logic [STACK_AW:0] sp;
        logic [STACK_DEPTH-1:0] stack;
        logic [NUM_VOUT-1:0] vout;
        logic [NUM_TIMERS-1:0] tstart;
        logic [NUM_ONESHOT-1:0] os_prev;
        logic [NUM_LATCH-1:0] latch;
        logic [NUM_VOUT-1:0] seen_vout;
        logic [NUM_TIMERS-1:0] seen_tmr;
        logic [5:0] os_idx;
        logic [5:0] la_idx;
        logic syntax_error;
        logic tick_pending;
        logic pass_done;
    } bee_state_type;

    bee_state_type state_r;
    bee_state_type state_nxt;
    bee_param_type list_r [LIST_DEPTH];

    // Gate evaluation over the top n stack entries.
    function automatic logic gate_eval(input bee_op_type op, input logic [STACK_DEPTH-1:0] stk,
                                       input logic [STACK_AW:0] sp, input logic [4:0] n);
        logic any1;
        logic all1;
        any1 = 1'b0;
        all1 = 1'b1;
        for (int i = 0; i < MAX_GATE_INPUTS; i++) begin
            if (i < int'(n)) begin
                any1 = any1 | stk[STACK_AW'(sp - STACK_AW'(i + 1))];
                all1 = all1 & stk[STACK_AW'(sp - STACK_AW'(i + 1))];
            end
        end
        case (op)
            OP_OR: gate_eval = any1;
            OP_AND: gate_eval = all1;
            OP_NOR: gate_eval = ~any1;
            default: gate_eval = ~all1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Parameter list with insert and delete editing.
    // ------------------------------------------------------------
    // Editing shifts the whole tail in one cycle; costly but keeps the list packed.
    genvar g;
    generate
        for (g = 0; g < LIST_DEPTH; g++) begin : gen_list
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    list_r[g] <= PARAM_END;
                end else if (state_r.phase == ST_IDLE && edit_req.cmd == ED_INSERT) begin
                    if (g > int'(edit_req.pos)) begin
                        list_r[g] <= list_r[(g + LIST_DEPTH - 1) % LIST_DEPTH];
                    end else if (g == int'(edit_req.pos)) begin
                        list_r[g] <= edit_req.param;
                    end
                end else if (state_r.phase == ST_IDLE && edit_req.cmd == ED_DELETE) begin
                    if (g >= int'(edit_req.pos)) begin
                        list_r[g] <= (g == LIST_DEPTH - 1) ? PARAM_END : list_r[(g + 1) % LIST_DEPTH];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Sequencer: syntax check after each change, then evaluation passes.
    // ------------------------------------------------------------
    always_comb begin
        bee_param_type p;
        logic [4:0] n;
        logic top;
        logic nxt_bit;
        logic last;
        p = list_r[state_r.pc];
        n = p.arg[4:0];
        top = state_r.stack[STACK_AW'(state_r.sp - 1'b1)];
        nxt_bit = state_r.stack[STACK_AW'(state_r.sp - 2'd2)];
        last = (state_r.pc == LIST_AW'(LIST_DEPTH - 1));
        state_nxt = state_r;
        state_nxt.pass_done = 1'b0;
        if (eval_tick) begin
            state_nxt.tick_pending = 1'b1;
        end
        case (state_r.phase)
            ST_IDLE: begin
                if (setting_change || edit_req.cmd != ED_NONE) begin
                    // A recompile clears latches and restarts the check.
                    state_nxt.latch = '0;
                    state_nxt.phase = ST_CHECK;
                    state_nxt.pc = '0;
                    state_nxt.seen_vout = '0;
                    state_nxt.seen_tmr = '0;
                    state_nxt.syntax_error = 1'b0;
                end else if (state_r.tick_pending && !state_r.syntax_error) begin
                    state_nxt.tick_pending = eval_tick;
                    state_nxt.phase = ST_EVAL;
                    state_nxt.pc = '0;
                    state_nxt.sp = '0;
                    state_nxt.os_idx = '0;
                    state_nxt.la_idx = '0;
                end
            end
            ST_CHECK: begin
                if (p.op == OP_ASSIGN) begin
                    if (state_r.seen_vout[p.arg[5:0]]) begin
                        state_nxt.syntax_error = 1'b1;
                    end
                    state_nxt.seen_vout[p.arg[5:0]] = 1'b1;
                end
                if (p.op == OP_TIMER) begin
                    if (state_r.seen_tmr[p.arg[4:0]]) begin
                        state_nxt.syntax_error = 1'b1;
                    end
                    state_nxt.seen_tmr[p.arg[4:0]] = 1'b1;
                end
                state_nxt.pc = state_r.pc + 1'b1;
                if (p.op == OP_END || last) begin
                    state_nxt.phase = ST_IDLE;
                end
            end
            ST_EVAL: begin
                // One parameter per cycle in list order.
                state_nxt.pc = state_r.pc + 1'b1;
                case (p.op)
                    OP_OPERAND: begin
                        state_nxt.stack[STACK_AW'(state_r.sp)] = operands[p.arg];
                        state_nxt.sp = state_r.sp + 1'b1;
                    end
                    OP_VOUT_READ: begin
                        state_nxt.stack[STACK_AW'(state_r.sp)] = state_r.vout[p.arg[5:0]];
                        state_nxt.sp = state_r.sp + 1'b1;
                    end
                    OP_TIMER_READ: begin
                        state_nxt.stack[STACK_AW'(state_r.sp)] = timer_out[p.arg[4:0]];
                        state_nxt.sp = state_r.sp + 1'b1;
                    end
                    OP_NOT: begin
                        state_nxt.stack[STACK_AW'(state_r.sp - 1'b1)] = ~top;
                    end
                    OP_OR, OP_AND, OP_NOR, OP_NAND: begin
                        // Counts outside 2..16 are clamped to stay on the stack.
                        if (n < 5'(MIN_GATE_INPUTS)) begin
                            n = 5'(MIN_GATE_INPUTS);
                        end
                        if (p.arg > 8'(MAX_GATE_INPUTS)) begin
                            n = 5'(MAX_GATE_INPUTS);
                        end
                        state_nxt.stack[STACK_AW'(state_r.sp - (STACK_AW + 1)'(n))] =
                            gate_eval(p.op, state_r.stack, state_r.sp, n);
                        state_nxt.sp = state_r.sp - (STACK_AW + 1)'(n) + 1'b1;
                    end
                    OP_XOR: begin
                        state_nxt.stack[STACK_AW'(state_r.sp - 2'd2)] = top ^ nxt_bit;
                        state_nxt.sp = state_r.sp - 1'b1;
                    end
                    OP_LATCH: begin
                        // Reset above set in priority; holds otherwise.
                        if (top) begin
                            state_nxt.latch[state_r.la_idx[4:0]] = 1'b0;
                        end else if (nxt_bit) begin
                            state_nxt.latch[state_r.la_idx[4:0]] = 1'b1;
                        end
                        state_nxt.stack[STACK_AW'(state_r.sp - 2'd2)] = state_nxt.latch[state_r.la_idx[4:0]];
                        state_nxt.sp = state_r.sp - 1'b1;
                        state_nxt.la_idx = state_r.la_idx + 1'b1;
                    end
                    OP_TIMER: begin
                        state_nxt.tstart[p.arg[4:0]] = top;
                        state_nxt.stack[STACK_AW'(state_r.sp - 1'b1)] = timer_out[p.arg[4:0]];
                    end
                    OP_ASSIGN: begin
                        state_nxt.vout[p.arg[5:0]] = top;
                        state_nxt.sp = '0;
                    end
                    OP_ONESHOT_POS, OP_ONESHOT_NEG, OP_ONESHOT_DUAL: begin
                        // Previous input kept per slot, so the pulse lasts one pass.
                        state_nxt.os_prev[state_r.os_idx[4:0]] = top;
                        if (p.op == OP_ONESHOT_POS) begin
                            state_nxt.stack[STACK_AW'(state_r.sp - 1'b1)] =
                                top & ~state_r.os_prev[state_r.os_idx[4:0]];
                        end else if (p.op == OP_ONESHOT_NEG) begin
                            state_nxt.stack[STACK_AW'(state_r.sp - 1'b1)] =
                                ~top & state_r.os_prev[state_r.os_idx[4:0]];
                        end else begin
                            state_nxt.stack[STACK_AW'(state_r.sp - 1'b1)] =
                                top ^ state_r.os_prev[state_r.os_idx[4:0]];
                        end
                        state_nxt.os_idx = state_r.os_idx + 1'b1;
                    end
                    default: begin
                        state_nxt.phase = ST_IDLE;
                        state_nxt.pass_done = 1'b1;
                    end
                endcase
                if (last && p.op != OP_END) begin
                    state_nxt.phase = ST_IDLE;
                    state_nxt.pass_done = 1'b1;
                end
            end
            default: begin
                state_nxt.phase = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register; reset clears latches and one-shot history.
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------
    assign timer_start = state_r.tstart;
    assign vout = state_r.vout;
    assign status.busy = (state_r.phase != ST_IDLE);
    assign status.syntax_error = state_r.syntax_error;
    assign status.pass_done = state_r.pass_done;

endmodule

/* File: inc/bee_pkg.sv */
package bee_pkg;

    // ------------------------------------------------------------
    // Sizes of the engine.
    // ------------------------------------------------------------
    localparam int LIST_DEPTH = 128;
    localparam int LIST_AW = 7;
    localparam int STACK_DEPTH = 32;
    localparam int STACK_AW = 5;
    localparam int NUM_OPERANDS = 256;
    localparam int NUM_VOUT = 64;
    localparam int NUM_TIMERS = 32;
    localparam int NUM_ONESHOT = 32;
    localparam int NUM_LATCH = 32;
    localparam int MIN_GATE_INPUTS = 2;
    localparam int MAX_GATE_INPUTS = 16;

    // ------------------------------------------------------------
    // Parameter word: an opcode and an 8-bit argument.
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_END, OP_OPERAND, OP_VOUT_READ, OP_TIMER_READ, OP_NOT, OP_OR, OP_AND,
        OP_NOR, OP_NAND, OP_XOR, OP_LATCH, OP_TIMER, OP_ASSIGN, OP_ONESHOT_POS,
        OP_ONESHOT_NEG, OP_ONESHOT_DUAL
    } bee_op_type;

    typedef struct packed {
        bee_op_type op;
        logic [7:0] arg;
    } bee_param_type;

    localparam bee_param_type PARAM_END = '{op: OP_END, arg: 8'h00};

    // Editor command from the configuration side.
    typedef enum logic [1:0] {
        ED_NONE, ED_INSERT, ED_DELETE
    } bee_edit_type;

    typedef struct packed {
        bee_edit_type cmd;
        logic [LIST_AW-1:0] pos;
        bee_param_type param;
    } bee_editreq_type;

    // Engine status.
    typedef struct packed {
        logic busy;
        logic syntax_error;
        logic pass_done;
    } bee_status_type;

endpackage

/* File: tb/bee_engine_checker.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port-level checks of the equation engine.
// ------------------------------------------------------------
module bee_engine_checker
    import bee_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire bee_editreq_type edit_req,
    input wire logic setting_change,
    input wire logic eval_tick,
    input wire logic [NUM_OPERANDS-1:0] operands,
    input wire logic [NUM_TIMERS-1:0] timer_out,
    input wire logic [NUM_TIMERS-1:0] timer_start,
    input wire logic [NUM_VOUT-1:0] vout,
    input wire bee_status_type status
);
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    pass_pulse_a: assert property (status.pass_done |=> !status.pass_done)
        else $error("pass done held longer than one cycle");
    pass_end_a: assert property (status.pass_done |-> !status.busy && $past(status.busy))
        else $error("pass done without a preceding busy pass");
    edit_start_a: assert property (!status.busy && edit_req.cmd != ED_NONE |=> status.busy)
        else $error("edit did not start a recompile");
    recompile_start_a: assert property (!status.busy && setting_change |=> status.busy)
        else $error("setting change did not start a recompile");
    tick_start_a: assert property (!status.busy && !status.syntax_error && eval_tick |-> ##[1:2] status.busy)
        else $error("tick did not start a pass");
    vout_hold_a: assert property (!status.busy |=> $stable(vout))
        else $error("virtual outputs changed while idle");
    timer_hold_a: assert property (!status.busy |=> $stable(timer_start))
        else $error("timer starts changed while idle");
    error_hold_a: assert property (!status.busy ##1 !status.busy |-> $stable(status.syntax_error))
        else $error("syntax flag changed while idle");
    error_stall_a: assert property (status.syntax_error && !status.busy && edit_req.cmd == ED_NONE
        && !setting_change |=> !status.busy)
        else $error("pass started despite a syntax error");
endmodule

/* File: tb/test_bee_engine.sv */
`timescale 1ns/1ps
module test_bee_engine
    import bee_pkg::*;
;
    logic clock;
    logic reset_n;
    logic setting_change;
    logic eval_tick;
    bee_editreq_type edit_req;
    logic [NUM_OPERANDS-1:0] operands;
    logic [NUM_TIMERS-1:0] timer_out;
    logic [NUM_TIMERS-1:0] timer_start;
    logic [NUM_VOUT-1:0] vout;
    bee_status_type status;
    int error_cnt = 0;
    int checked = 0;
    int len = 0;

    bee_engine u_dut (.clock(clock), .reset_n(reset_n), .edit_req(edit_req), .setting_change(setting_change),
        .eval_tick(eval_tick), .operands(operands), .timer_out(timer_out), .timer_start(timer_start),
        .vout(vout), .status(status));

    // ------------------------------------------------------------
    // Shared helpers.
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Holds the request for exactly one edge; while busy it would be dropped silently.
    task automatic send(bee_edit_type c, int p, bee_op_type o, int a);
        @(posedge clock);
        #1;
        edit_req = '{cmd: c, pos: p[LIST_AW-1:0], param: '{op: o, arg: a[7:0]}};
        @(posedge clock);
        #1;
        edit_req.cmd = ED_NONE;
    endtask

    task automatic edit(bee_edit_type c, int p, bee_op_type o, int a);
        int n;
        send(c, p, o, a);
        n = 0;
        while (status.busy !== 1'h0 && n < 600) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("idle", 64'h0, 64'(status.busy));
    endtask

    task automatic add(bee_op_type o, int a);
        edit(ED_INSERT, len, o, a);
        len++;
    endtask

    task automatic wait_pass();
        int n;
        n = 0;
        while (status.pass_done !== 1'h1 && n < 600) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("pass_done", 64'h1, 64'(status.pass_done));
    endtask

    task automatic run_pass();
        @(posedge clock);
        #1;
        eval_tick = 1'h1;
        @(posedge clock);
        #1;
        eval_tick = 1'h0;
        wait_pass();
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic test_gates();
        bee_op_type g [5] = '{OP_OR, OP_AND, OP_NOR, OP_NAND, OP_XOR};
        logic a;
        logic b;
        for (int k = 0; k < 5; k++) begin
            add(OP_OPERAND, 0);
            add(OP_OPERAND, 1);
            add(g[k], 2);
            add(OP_ASSIGN, k);
        end
        add(OP_OPERAND, 0);
        add(OP_NOT, 0);
        add(OP_ASSIGN, 5);
        for (int i = 0; i < 16; i++) begin
            add(OP_OPERAND, i);
        end
        add(OP_AND, 16);
        add(OP_ASSIGN, 12);
        add(OP_VOUT_READ, 0);
        add(OP_VOUT_READ, 1);
        add(OP_XOR, 2);
        add(OP_ASSIGN, 13);
        for (int c = 0; c < 4; c++) begin
            operands[15:0] = {14'h0000, c[1:0]};
            run_pass();
            a = c[0];
            b = c[1];
            chk("gates", 64'({~a, a ^ b, ~(a & b), ~(a | b), a & b, a | b}), 64'(vout[5:0]));
            chk("vout_read", 64'(a ^ b), 64'(vout[13]));
        end
        operands[15:0] = 16'hffff;
        run_pass();
        chk("and16", 64'h1, 64'(vout[12]));
        operands[15:0] = 16'h7fff;
        run_pass();
        chk("and16", 64'h0, 64'(vout[12]));
        $display("gates test done");
    endtask

    task automatic test_latch();
        logic [5:0] s = 6'h15;
        logic [5:0] r = 6'h04;
        logic [5:0] e = 6'h33;
        add(OP_OPERAND, 2);
        add(OP_OPERAND, 3);
        add(OP_LATCH, 0);
        add(OP_ASSIGN, 6);
        for (int i = 0; i < 6; i++) begin
            operands[3:2] = {r[i], s[i]};
            run_pass();
            chk("latch", 64'(e[i]), 64'(vout[6]));
        end
        @(posedge clock);
        #1;
        setting_change = 1'h1;
        @(posedge clock);
        #1;
        setting_change = 1'h0;
        edit(ED_NONE, 0, OP_END, 0);
        operands[3:2] = 2'h0;
        run_pass();
        chk("latch_clear", 64'h0, 64'(vout[6]));
        $display("latch test done");
    endtask

    task automatic test_oneshot();
        logic [3:0] v = 4'h3;
        logic [3:0] p = 4'h1;
        logic [3:0] n = 4'h4;
        logic [3:0] d = 4'h5;
        for (int k = 0; k < 3; k++) begin
            add(OP_OPERAND, 4);
            add(bee_op_type'(int'(OP_ONESHOT_POS) + k), 0);
            add(OP_ASSIGN, 7 + k);
        end
        operands[4] = 1'h0;
        run_pass();
        for (int i = 0; i < 4; i++) begin
            operands[4] = v[i];
            run_pass();
            chk("oneshot", 64'({d[i], n[i], p[i]}), 64'(vout[9:7]));
        end
        $display("one-shot test done");
    endtask

    task automatic test_timer();
        add(OP_OPERAND, 5);
        add(OP_TIMER, 31);
        add(OP_ASSIGN, 10);
        add(OP_TIMER_READ, 31);
        add(OP_ASSIGN, 14);
        for (int c = 0; c < 4; c++) begin
            operands[5] = c[0];
            timer_out[31] = c[1];
            run_pass();
            chk("timer_start", 64'(c[0]), 64'(timer_start[31]));
            chk("timer_value", 64'(c[1]), 64'(vout[10]));
            chk("timer_read", 64'(c[1]), 64'(vout[14]));
        end
        $display("timer test done");
    endtask

    task automatic test_end();
        edit(ED_INSERT, len + 1, OP_OPERAND, 6);
        edit(ED_INSERT, len + 2, OP_ASSIGN, 11);
        operands[6] = 1'h1;
        run_pass();
        chk("after_end", 64'h0, 64'(vout[11]));
        edit(ED_DELETE, len, OP_END, 0);
        len += 2;
        run_pass();
        chk("after_delete", 64'h1, 64'(vout[11]));
        $display("end test done");
    endtask

    task automatic test_syntax();
        int seen;
        add(OP_OPERAND, 0);
        add(OP_ASSIGN, 0);
        chk("syntax_error", 64'h1, 64'(status.syntax_error));
        seen = 0;
        @(posedge clock);
        #1;
        eval_tick = 1'h1;
        for (int i = 0; i < 150; i++) begin
            @(posedge clock);
            #1;
            eval_tick = 1'h0;
            seen += int'(status.pass_done === 1'h1);
        end
        chk("blocked_passes", 64'h0, 64'(seen));
        send(ED_DELETE, len - 1, OP_END, 0);
        wait_pass();
        chk("syntax_error", 64'h0, 64'(status.syntax_error));
        $display("syntax test done");
    endtask

    // ------------------------------------------------------------
    // Run control.
    // ------------------------------------------------------------
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Free-running 100 MHz clock.
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    // The run needs a few thousand cycles; the limit leaves wide margin for slow checks.
    initial begin
        #500000;
        error_cnt++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        conclude();
    end

    // Main sequence: reset, then every scenario in turn.
    initial begin
        reset_n = 1'h0;
        edit_req = '0;
        setting_change = 1'h0;
        eval_tick = 1'h0;
        operands = '0;
        timer_out = '0;
        repeat (4) @(posedge clock);
        #1;
        reset_n = 1'h1;
        chk("vout_reset", 64'h0, vout);
        chk("timer_reset", 64'h0, 64'(timer_start));
        test_gates();
        test_latch();
        test_oneshot();
        test_timer();
        test_end();
        test_syntax();
        conclude();
    end
endmodule

bind bee_engine bee_engine_checker u_chk (.clock(clock), .reset_n(reset_n), .edit_req(edit_req),
    .setting_change(setting_change), .eval_tick(eval_tick), .operands(operands), .timer_out(timer_out),
    .timer_start(timer_start), .vout(vout), .status(status));
